// *** adcaf_consts.svh ***
// register addresses, field positions and reset values of the alarm flag registers
`ifndef ADCAF_CONSTS_SVH
`define ADCAF_CONSTS_SVH

`define ADCAF_ALARM_FLAGS_ADDR        8'h20
`define ADCAF_HIGH_LIMIT_ADDR         8'h24
`define ADCAF_LOW_LIMIT_ADDR          8'h28

`define ADCAF_POS_SUPPLY_LOW_ACTIVE   15
`define ADCAF_POS_SUPPLY_HIGH_ACTIVE  14
`define ADCAF_POS_INPUT_HIGH_ACTIVE   11
`define ADCAF_POS_INPUT_LOW_ACTIVE    10
`define ADCAF_POS_TRIP_MSB            7
`define ADCAF_POS_TRIP_LSB            4
`define ADCAF_POS_ANY_ALARM           0
`define ADCAF_POS_HYST_MSB            7
`define ADCAF_POS_HYST_LSB            6

`define ADCAF_HYST_RST                8'h00
`define ADCAF_HIGH_LIMIT_RST          16'hffff
`define ADCAF_LOW_LIMIT_RST           16'h0000
`define ADCAF_TRIP_RST                4'h0

`define ADCAF_PIN_TRISTATE            2'h0
`define ADCAF_PIN_ALARM               2'h1
`define ADCAF_PIN_GPO                 2'h2
`define ADCAF_PIN_SERIAL              2'h3

`define ADCAF_APPEND_NONE             2'h0
`define ADCAF_APPEND_HIGH             2'h1
`define ADCAF_APPEND_LOW              2'h2
`define ADCAF_APPEND_BOTH             2'h3

`endif

// *** adcaf_host.sv ***
// host controller model driving the byte register port
`timescale 1ns/100ps
module adcaf_host (
    // clock
    input  wire logic       clk,
    // byte register port
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
    end

    // one byte write, strobe held for exactly one taking edge
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask

    // one byte read, answer taken at the edge that ends its valid cycle
    task automatic rd_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
        v = reg_rvalid;
    endtask

    // limit write, low byte first, unused nibble forced to zero
    task automatic wr_limit(input logic [7:0] base, input logic [15:0] lim);
        wr_byte(base, {lim[7:4], 4'h0});
        wr_byte(base + 8'h01, lim[15:8]);
    endtask
endmodule // adcaf_host

// *** adcaf_limit_cmp.sv ***
// one input limit comparator with hysteresis, upper or lower sense
`timescale 1ns/100ps
module adcaf_limit_cmp #(
    parameter bit UPPER = 1'b1
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // conversion result
    input  wire logic        conv_valid,
    input  wire logic [11:0] conv_data,
    // limit and hysteresis
    input  wire logic [11:0] limit,
    input  wire logic [1:0]  hyst,
    // active flag
    output logic             active
);

    adcaf_pkg::adcaf_cmp_state_t state;
    adcaf_pkg::adcaf_cmp_state_t next_state;
    logic [12:0]                 data_ext;
    logic [12:0]                 lim_ext;
    logic [12:0]                 hyst_ext;
    logic                        crossed;
    logic                        returned;

    ////////////////////////////////////////////////////////////////////////////
    // compare and release with hysteresis
    always_comb begin
        data_ext = {1'b0, conv_data};
        lim_ext  = {1'b0, limit};
        hyst_ext = {11'h000, hyst};
        if (UPPER) begin
            crossed  = data_ext > lim_ext;
            returned = (data_ext + hyst_ext) < lim_ext;
        end else begin
            crossed  = data_ext < lim_ext;
            returned = data_ext > (lim_ext + hyst_ext);
        end
        next_state = state;
        if (conv_valid) begin
            if (!state.active && crossed) begin
                next_state.active = 1'b1;
            end else if (state.active && returned) begin
                next_state.active = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign active = state.active;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    limit_assert_a : assert property (
        @(posedge clk) disable iff (rst)
        conv_valid && crossed |=> active)
        else $error("active flag did not rise on crossing");

    limit_release_a : assert property (
        @(posedge clk) disable iff (rst)
        conv_valid && active && returned |=> !active)
        else $error("active flag did not release after hysteresis");

    limit_hold_a : assert property (
        @(posedge clk) disable iff (rst)
        active && !conv_valid |=> active)
        else $error("active flag changed without a conversion");

endmodule // adcaf_limit_cmp

// *** adcaf_pkg.sv ***
// state types of the alarm flag register block
package adcaf_pkg;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [1:0] level;
    } adcaf_sync_state_t;

    typedef struct packed {
        logic active;
    } adcaf_cmp_state_t;

    typedef struct packed {
        logic [7:0]  hyst;
        logic [15:0] high_lim;
        logic [15:0] low_lim;
        logic [3:0]  trip;
        logic        any;
        logic [7:0]  rdata;
        logic        rvalid;
        logic [1:0]  fbits;
        logic [1:0]  fcount;
        logic        pin_o;
        logic        pin_oe;
    } adcaf_top_state_t;

endpackage

// *** adcaf_sync.sv ***
// three-stage synchroniser with agreement filter for the supply comparator pins
`timescale 1ns/100ps
module adcaf_sync (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // raw pins and filtered levels
    input  wire logic [1:0] raw,
    output logic      [1:0] level
);

    adcaf_pkg::adcaf_sync_state_t state;
    adcaf_pkg::adcaf_sync_state_t next_state;
    logic [1:0]                   next_level;

    ////////////////////////////////////////////////////////////////////////////
    // a change counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_bit
            assign next_level[gi] = (state.s2[gi] == state.s3[gi]) ? state.s3[gi]
                                                                   : state.level[gi];
        end
    endgenerate

    always_comb begin
        next_state       = state;
        next_state.s1    = raw;
        next_state.s2    = state.s1;
        next_state.s3    = state.s2;
        next_state.level = next_level;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign level = state.level;

endmodule // adcaf_sync

// *** adcaf_top.sv ***
// alarm status and limit registers with active and latched flags
`timescale 1ns/100ps
`include "adcaf_consts.svh"

// Contract
// - read-only alarm status word at 20h
// - bits 15,14 show supply low, high
// - bits 11,10 show input high, low
// - bits 7-4 latched: supply lo, hi, input
// - bit 0 ORs all latched flags
// - flags one when condition, reset to zero
// - reserved bits read zero, not writable; code stores and reads back hysteresis bits 29-24 and limit bits 3-0
// - hysteresis byte 31-24 at 24h, top two used
// - upper limit bits 15-4 used, resets ffff
// - lower limit at 28h, resets zero
// - word spans four bytes, low byte first
// - append field picks input flags for frame
// - pin code 01 drives alarm indication
module adcaf_top (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // byte register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rvalid,
    // conversion results
    input  wire logic        conv_valid,
    input  wire logic [11:0] conv_data,
    // supply comparator pins
    input  wire logic        supply_low_raw,
    input  wire logic        supply_high_raw,
    // settings held elsewhere
    input  wire logic [1:0]  append_input_alarm_bits,
    input  wire logic [1:0]  second_output_pin_function,
    input  wire logic        serial_data_1,
    input  wire logic        gpo_value,
    // frame flag bits
    output logic      [1:0]  frame_alarm_bits,
    output logic      [1:0]  frame_alarm_count,
    // second serial output pin
    output logic             second_serial_output,
    output logic             second_serial_output_oe
);

    adcaf_pkg::adcaf_top_state_t state;
    adcaf_pkg::adcaf_top_state_t next_state;
    logic [1:0]                  supply_level;
    logic                        supply_low;
    logic                        supply_high;
    logic                        input_high;
    logic                        input_low;
    logic [3:0]                  active_set;
    logic [31:0]                 status_word;
    logic [31:0]                 high_word;
    logic [31:0]                 low_word;
    logic [31:0]                 sel_word;
    logic [7:0]                  sel_byte;
    logic                        status_clear;

    ////////////////////////////////////////////////////////////////////////////
    // supply pins and input comparators
    adcaf_sync u_sync (
        .clk   (clk),
        .rst   (rst),
        .raw   ({supply_high_raw, supply_low_raw}),
        .level (supply_level)
    );

    assign supply_low  = supply_level[0];
    assign supply_high = supply_level[1];

    adcaf_limit_cmp #(.UPPER(1'b1)) u_high (
        .clk        (clk),
        .rst        (rst),
        .conv_valid (conv_valid),
        .conv_data  (conv_data),
        .limit      (state.high_lim[15:4]),
        .hyst       (state.hyst[`ADCAF_POS_HYST_MSB:`ADCAF_POS_HYST_LSB]),
        .active     (input_high)
    );

    adcaf_limit_cmp #(.UPPER(1'b0)) u_low (
        .clk        (clk),
        .rst        (rst),
        .conv_valid (conv_valid),
        .conv_data  (conv_data),
        .limit      (state.low_lim[15:4]),
        .hyst       (state.hyst[`ADCAF_POS_HYST_MSB:`ADCAF_POS_HYST_LSB]),
        .active     (input_low)
    );

    assign active_set = {supply_low, supply_high, input_high, input_low};

    ////////////////////////////////////////////////////////////////////////////
    // register words
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`ADCAF_POS_SUPPLY_LOW_ACTIVE]  = supply_low;
        status_word[`ADCAF_POS_SUPPLY_HIGH_ACTIVE] = supply_high;
        status_word[`ADCAF_POS_INPUT_HIGH_ACTIVE]  = input_high;
        status_word[`ADCAF_POS_INPUT_LOW_ACTIVE]   = input_low;
        status_word[`ADCAF_POS_TRIP_MSB:`ADCAF_POS_TRIP_LSB] = state.trip;
        status_word[`ADCAF_POS_ANY_ALARM]          = state.any;
        high_word = {state.hyst, 8'h00, state.high_lim};
        low_word  = {16'h0000, state.low_lim};
        case ({reg_addr[7:2], 2'b00})
            `ADCAF_ALARM_FLAGS_ADDR: begin
                sel_word = status_word;
            end
            `ADCAF_HIGH_LIMIT_ADDR: begin
                sel_word = high_word;
            end
            `ADCAF_LOW_LIMIT_ADDR: begin
                sel_word = low_word;
            end
            default: begin
                sel_word = 32'h0000_0000;
            end
        endcase
        case (reg_addr[1:0])
            2'h0: sel_byte = sel_word[7:0];
            2'h1: sel_byte = sel_word[15:8];
            2'h2: sel_byte = sel_word[23:16];
            default: sel_byte = sel_word[31:24];
        endcase
    end

    // reading the byte that holds the latched flags releases them
    assign status_clear = reg_rd && (reg_addr == `ADCAF_ALARM_FLAGS_ADDR);

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_state        = state;
        next_state.rvalid = reg_rd;
        next_state.rdata  = reg_rd ? sel_byte : 8'h00;
        if (reg_wr) begin
            case (reg_addr)
                `ADCAF_HIGH_LIMIT_ADDR: begin
                    next_state.high_lim[7:0] = reg_wdata;
                end
                `ADCAF_HIGH_LIMIT_ADDR + 8'h01: begin
                    next_state.high_lim[15:8] = reg_wdata;
                end
                `ADCAF_HIGH_LIMIT_ADDR + 8'h03: begin
                    next_state.hyst = reg_wdata;
                end
                `ADCAF_LOW_LIMIT_ADDR: begin
                    next_state.low_lim[7:0] = reg_wdata;
                end
                `ADCAF_LOW_LIMIT_ADDR + 8'h01: begin
                    next_state.low_lim[15:8] = reg_wdata;
                end
                default: begin
                    next_state.hyst = state.hyst;
                end
            endcase
        end
        // a condition present in the clearing cycle keeps its flag
        next_state.trip = (state.trip & ~{4{status_clear}}) | active_set;
        next_state.any  = |next_state.trip;
        case (append_input_alarm_bits)
            `ADCAF_APPEND_HIGH: begin
                next_state.fbits  = {1'b0, input_high};
                next_state.fcount = 2'h1;
            end
            `ADCAF_APPEND_LOW: begin
                next_state.fbits  = {1'b0, input_low};
                next_state.fcount = 2'h1;
            end
            `ADCAF_APPEND_BOTH: begin
                next_state.fbits  = {input_high, input_low};
                next_state.fcount = 2'h2;
            end
            default: begin
                next_state.fbits  = 2'h0;
                next_state.fcount = 2'h0;
            end
        endcase
        case (second_output_pin_function)
            `ADCAF_PIN_ALARM: begin
                next_state.pin_o  = next_state.any;
                next_state.pin_oe = 1'b1;
            end
            `ADCAF_PIN_GPO: begin
                next_state.pin_o  = gpo_value;
                next_state.pin_oe = 1'b1;
            end
            `ADCAF_PIN_SERIAL: begin
                next_state.pin_o  = serial_data_1;
                next_state.pin_oe = 1'b1;
            end
            default: begin
                next_state.pin_o  = 1'b0;
                next_state.pin_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state          <= '0;
            state.hyst     <= `ADCAF_HYST_RST;
            state.high_lim <= `ADCAF_HIGH_LIMIT_RST;
            state.low_lim  <= `ADCAF_LOW_LIMIT_RST;
            state.trip     <= `ADCAF_TRIP_RST;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata               = state.rdata;
    assign reg_rvalid              = state.rvalid;
    assign frame_alarm_bits        = state.fbits;
    assign frame_alarm_count       = state.fcount;
    assign second_serial_output    = state.pin_o;
    assign second_serial_output_oe = state.pin_oe;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    status_reserved_a : assert property (
        @(posedge clk) disable iff (rst)
        reg_rd && (reg_addr == 8'h22 || reg_addr == 8'h23 || reg_addr == 8'h26)
        |=> reg_rvalid && reg_rdata == 8'h00)
        else $error("reserved byte read nonzero");

    supply_active_a : assert property (
        @(posedge clk) disable iff (rst)
        reg_rd && reg_addr == 8'h21
        |=> reg_rdata[7] == $past(supply_low) && reg_rdata[6] == $past(supply_high)
            && reg_rdata[5:4] == 2'b00)
        else $error("supply active bits wrong");

    input_active_a : assert property (
        @(posedge clk) disable iff (rst)
        reg_rd && reg_addr == 8'h21
        |=> reg_rdata[3] == $past(input_high) && reg_rdata[2] == $past(input_low))
        else $error("input active bits wrong");

    trip_sticky_a : assert property (
        @(posedge clk) disable iff (rst)
        (|state.trip) && !status_clear |=> (state.trip & $past(state.trip)) == $past(state.trip))
        else $error("latched flag dropped without a read");

    trip_clear_a : assert property (
        @(posedge clk) disable iff (rst)
        status_clear && active_set == 4'h0 |=> state.trip == 4'h0 && !state.any)
        else $error("latched flags not released by read");

    any_alarm_a : assert property (
        @(posedge clk) disable iff (rst)
        state.any == (|state.trip))
        else $error("summary alarm mismatch");

    reset_values_a : assert property (
        @(posedge clk)
        rst |=> state.trip == 4'h0 && state.high_lim == 16'hffff
                && state.low_lim == 16'h0000 && state.hyst == 8'h00)
        else $error("reset values wrong");

    byte_order_a : assert property (
        @(posedge clk) disable iff (rst)
        reg_wr && reg_addr == 8'h25 |=> state.high_lim[15:8] == $past(reg_wdata))
        else $error("high limit upper byte not written");

    frame_both_a : assert property (
        @(posedge clk) disable iff (rst)
        append_input_alarm_bits == 2'h3
        |=> frame_alarm_count == 2'h2
            && frame_alarm_bits == {$past(input_high), $past(input_low)})
        else $error("frame flag bits wrong");

    pin_alarm_a : assert property (
        @(posedge clk) disable iff (rst)
        second_output_pin_function == 2'h1 |=> second_serial_output_oe
            && second_serial_output == state.any)
        else $error("second output not showing alarm");

    read_idle_a : assert property (
        @(posedge clk) disable iff (rst)
        !reg_rd |=> !reg_rvalid && reg_rdata == 8'h00)
        else $error("read answer without a read");

    reserved_write_a : assert property (
        @(posedge clk) disable iff (rst)
        reg_wr && (reg_addr[7:2] == 6'h08 || reg_addr == 8'h26 || reg_addr == 8'h2a)
        |=> $stable(high_word) && $stable(low_word))
        else $error("read-only byte accepted a write");

    trip_set_c : cover property (@(posedge clk) disable iff (rst) $rose(state.trip[1]));
    trip_read_c : cover property (@(posedge clk) disable iff (rst)
        status_clear && (|state.trip) ##1 state.trip == 4'h0);
    pin_alarm_c : cover property (@(posedge clk) disable iff (rst)
        second_serial_output_oe && second_serial_output);
    supply_trip_c : cover property (@(posedge clk) disable iff (rst) $rose(state.trip[3]));

endmodule // adcaf_top

// *** adcaf_top_test.sv ***
// self-checking testbench of the alarm flag register block
`timescale 1ns/100ps
module adcaf_top_test;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic [7:0]  reg_wdata;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        reg_rvalid;
    logic        conv_valid = 1'b0;
    logic [11:0] conv_data = 12'h000;
    logic        sup_lo = 1'b0;
    logic        sup_hi = 1'b0;
    logic [1:0]  append = 2'h0;
    logic [1:0]  pin_fn = 2'h1;
    logic        sdata = 1'b0;
    logic        gpo = 1'b1;
    logic [1:0]  fbits;
    logic [1:0]  fcount;
    logic        pin_o;
    logic        pin_oe;
    int          n_fail = 0;
    int          total_checks = 0;

    always #12.5 clk = ~clk;

    adcaf_host host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    adcaf_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .conv_valid(conv_valid), .conv_data(conv_data),
        .supply_low_raw(sup_lo), .supply_high_raw(sup_hi),
        .append_input_alarm_bits(append), .second_output_pin_function(pin_fn),
        .serial_data_1(sdata), .gpo_value(gpo), .frame_alarm_bits(fbits),
        .frame_alarm_count(fcount), .second_serial_output(pin_o),
        .second_serial_output_oe(pin_oe));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        host.rd_byte(a, d, v);
        check({7'h00, v}, 8'h01, "read valid");
        check(d, exp, $sformatf("byte %h", a));
    endtask

    // conversion pulse, then wait until latched flags and pin have moved
    task automatic conv(input logic [11:0] d);
        @(posedge clk);
        conv_valid <= 1'b1;
        conv_data  <= d;
        @(posedge clk);
        conv_valid <= 1'b0;
        @(posedge clk);
        @(posedge clk);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset;
        for (int i = 0; i < 13; i++) begin
            rd_chk(8'h20 + i[7:0], (i == 4 || i == 5) ? 8'hff : 8'h00);
        end
        $display("test reset values done");
    endtask

    task automatic test_read_only;
        host.wr_byte(8'h20, 8'hff);
        host.wr_byte(8'h21, 8'hff);
        host.wr_byte(8'h26, 8'hff);
        host.wr_byte(8'h2a, 8'hff);
        rd_chk(8'h20, 8'h00);
        rd_chk(8'h21, 8'h00);
        rd_chk(8'h26, 8'h00);
        rd_chk(8'h2a, 8'h00);
        $display("test read-only done");
    endtask

    task automatic test_high_alarm;
        host.wr_limit(8'h24, 16'h8000);
        host.wr_byte(8'h27, 8'h40);
        rd_chk(8'h24, 8'h00);
        rd_chk(8'h25, 8'h80);
        rd_chk(8'h27, 8'h40);
        pin_fn <= 2'h1;
        append <= 2'h1;
        conv(12'h800);
        rd_chk(8'h20, 8'h00);
        conv(12'h801);
        check({7'h00, pin_o}, 8'h01, "alarm pin");
        check({7'h00, pin_oe}, 8'h01, "alarm pin drive");
        check({6'h00, fbits}, 8'h01, "frame bits high");
        check({6'h00, fcount}, 8'h01, "frame count high");
        rd_chk(8'h21, 8'h08);
        conv(12'h7ff);
        rd_chk(8'h21, 8'h08);
        conv(12'h7fe);
        rd_chk(8'h21, 8'h00);
        rd_chk(8'h21, 8'h00);
        rd_chk(8'h20, 8'h21);
        rd_chk(8'h20, 8'h00);
        check({7'h00, pin_o}, 8'h00, "alarm pin cleared");
        $display("test high alarm done");
    endtask

    task automatic test_low_and_frame;
        logic [1:0] eb[4];
        logic [1:0] ec[4];
        eb = '{2'h0, 2'h1, 2'h1, 2'h3};
        ec = '{2'h0, 2'h1, 2'h1, 2'h2};
        host.wr_limit(8'h28, 16'h0100);
        rd_chk(8'h28, 8'h00);
        rd_chk(8'h29, 8'h01);
        conv(12'h00f);
        rd_chk(8'h21, 8'h04);
        rd_chk(8'h20, 8'h11);
        host.wr_limit(8'h28, 16'h9000);
        conv(12'h850);
        rd_chk(8'h21, 8'h0c);
        for (int m = 0; m < 4; m++) begin
            append <= m[1:0];
            repeat (2) @(posedge clk);
            check({6'h00, fbits}, {6'h00, eb[m]}, "frame bits");
            check({6'h00, fcount}, {6'h00, ec[m]}, "frame count");
        end
        rd_chk(8'h20, 8'h31);
        rd_chk(8'h20, 8'h31);
        $display("test low alarm and frame done");
    endtask

    task automatic test_pin_modes;
        pin_fn <= 2'h0;
        repeat (2) @(posedge clk);
        check({7'h00, pin_oe}, 8'h00, "pin released");
        pin_fn <= 2'h2;
        repeat (2) @(posedge clk);
        check({6'h00, pin_oe, pin_o}, 8'h03, "pin gpo");
        pin_fn <= 2'h3;
        repeat (2) @(posedge clk);
        check({6'h00, pin_oe, pin_o}, 8'h02, "pin serial data");
        sdata  <= 1'b1;
        gpo    <= 1'b0;
        repeat (2) @(posedge clk);
        check({6'h00, pin_oe, pin_o}, 8'h03, "pin serial data high");
        $display("test pin modes done");
    endtask

    task automatic test_supply;
        host.wr_limit(8'h28, 16'h0000);
        host.wr_limit(8'h24, 16'hfff0);
        conv(12'h500);
        rd_chk(8'h20, 8'h31);
        rd_chk(8'h20, 8'h00);
        sup_lo <= 1'b1;
        repeat (8) @(posedge clk);
        rd_chk(8'h21, 8'h80);
        sup_lo <= 1'b0;
        sup_hi <= 1'b1;
        repeat (8) @(posedge clk);
        rd_chk(8'h21, 8'h40);
        rd_chk(8'h20, 8'hc1);
        rd_chk(8'h20, 8'h41);
        $display("test supply alarms done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_read_only();
        test_high_alarm();
        test_low_and_frame();
        test_pin_modes();
        test_supply();
        complete_run();
    end

    // watchdog, tests take well under a thousand cycles
    initial begin
        #(25 * 5000);
        n_fail++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule // adcaf_top_test
